/* recnt_pkg.sv */
// Shared constants and carrier types for the rotary encoder counter target.
// Assumes a 100 MHz system clock and a separate encoder sampling clock.
`default_nettype none
package recnt_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS = 10;    // System clock period
  localparam int SCL_MAX_KHZ = 400;     // Fastest bus clock served
  localparam int TX_SETUP_NS = 100;     // Clock hold time while a read byte is prepared
  localparam int STRETCH_CYC = (TX_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register indexes
  localparam logic [4:0] IDX_GENERAL_CONFIGURATION = 5'h00;   // general_configuration
  localparam logic [4:0] IDX_GCONF2 = 5'h01;  // second configuration
  localparam logic [4:0] IDX_INTCFG = 5'h02;  // interrupt source enables
  localparam logic [4:0] IDX_STATUS = 5'h03;  // encoder_event_status
  localparam logic [4:0] IDX_WORD0 = 5'h08;   // First byte of the four 32-bit words
  localparam logic [4:0] IDX_LAST = 5'h17;    // Last mapped index
  // Word slots
  localparam logic [1:0] W_COUNT = 2'h0;  // counter_value
  localparam logic [1:0] W_INC = 2'h1;    // increment_amount
  localparam logic [1:0] W_UPPER = 2'h2;  // upper_threshold
  localparam logic [1:0] W_LOWER = 2'h3;  // lower_threshold
  // Field positions
  localparam int GC_WRAP_BIT = 0;      // wrap_enable
  localparam int GC_SINGLE_BIT = 1;    // single_edge_counting
  localparam int GC2_STRETCH_BIT = 0;  // clock_stretch_enable
  localparam int ST_UP_BIT = 0;        // Step clockwise
  localparam int ST_DOWN_BIT = 1;      // Step counter-clockwise
  localparam int ST_MAX_BIT = 2;       // Upper threshold reached
  localparam int ST_MIN_BIT = 3;       // Lower threshold reached
  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_INC = 32'h0000_0001;
  localparam logic [31:0] RST_UPPER = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_LOWER = 32'h8000_0000;
  // One encoder step as seen by the counter
  typedef struct packed {
    logic valid;  // One-cycle step strobe
    logic up;     // Direction: 1 adds, 0 subtracts
  } recnt_step_t;
  // Bus target states
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} recnt_bus_state_t;
endpackage : recnt_pkg
`default_nettype wire

/* recnt_quad.sv */
// Encoder front end running on the encoder sampling clock.
// Assumes channel pins are asynchronous; hands each step to clk by toggle.
`default_nettype none
module recnt_quad (
  // System side
  input wire logic clk,
  input wire logic rst_b,
  input wire logic single_edge_counting,
  output recnt_pkg::recnt_step_t step,
  // Link side
  input wire logic enc_clk,
  input wire logic enc_rst_b,
  input wire logic chan_a,
  input wire logic chan_b
);
  // Encoder-domain pin and mode synchronisers
  logic [1:0] a_sync_q, a_sync_d;
  logic [1:0] b_sync_q, b_sync_d;
  logic [1:0] m_sync_q, m_sync_d;
  logic a_prev_q, a_prev_d;    // Last synchronised A
  logic tog_q, tog_d;          // Flips once per step
  logic dir_q, dir_d;          // Held stable from flip to next flip
  // System-domain receive side
  logic [2:0] t_sync_q, t_sync_d;  // Toggle sync plus edge history
  recnt_pkg::recnt_step_t step_q, step_d;

  // Encoder domain next state
  always_comb begin
    a_sync_d = {a_sync_q[0], chan_a};
    b_sync_d = {b_sync_q[0], chan_b};
    m_sync_d = {m_sync_q[0], single_edge_counting};
    a_prev_d = a_sync_q[1];
    tog_d = tog_q;
    dir_d = dir_q;
    if (a_prev_q && !a_sync_q[1]) begin
      // Falling A: B high means clockwise
      tog_d = !tog_q;
      dir_d = b_sync_q[1];
    end else if (!a_prev_q && a_sync_q[1] && !m_sync_q[1]) begin
      // Double-edge mode also counts rising A, sense inverted
      tog_d = !tog_q;
      dir_d = !b_sync_q[1];
    end
  end

  // Encoder domain registers
  always_ff @(posedge enc_clk) begin
    if (!enc_rst_b) begin
      // Channels rest high on their pull-ups; a low reset value would fake an A edge
      a_sync_q <= 2'h3;
      b_sync_q <= 2'h3;
      m_sync_q <= 2'h0;
      a_prev_q <= 1'b1;
      tog_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      a_sync_q <= a_sync_d;
      b_sync_q <= b_sync_d;
      m_sync_q <= m_sync_d;
      a_prev_q <= a_prev_d;
      tog_q <= tog_d;
      dir_q <= dir_d;
    end
  end

  // System domain: a toggle edge marks one step; dir has long settled by then
  always_comb begin
    t_sync_d = {t_sync_q[1:0], tog_q};
    step_d.valid = t_sync_q[2] ^ t_sync_q[1];
    step_d.up = dir_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      t_sync_q <= 3'h0;
      step_q <= '0;
    end else begin
      t_sync_q <= t_sync_d;
      step_q <= step_d;
    end
  end

  assign step = step_q;

  // Single-edge mode: rising A never produces a step
  AST_SINGLE_RISE: assert property (@(posedge enc_clk) disable iff (!enc_rst_b)
    (m_sync_q[1] && !a_prev_q && a_sync_q[1]) |=> (tog_q == $past(tog_q)))
    else $error("step counted on rising channel A in single-edge mode");
endmodule : recnt_quad
`default_nettype wire

/* recnt_top.sv */
// Rotary encoder counter with a two-wire serial register target.
// Assumes bus pins and jumpers are asynchronous to clk; pads resolve open drain.
`default_nettype none
module recnt_top (
  // System
  input wire logic clk,
  input wire logic rst_b,
  // Encoder link
  input wire logic enc_clk,
  input wire logic enc_rst_b,
  input wire logic chan_a,
  input wire logic chan_b,
  // Address jumpers, bit 6 is the most significant
  input wire logic [6:0] address_jumper_inputs,
  // Serial bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Open-drain interrupt
  output logic int_n_o,
  output logic int_n_oe
);
  // Pin synchronisers; stage 2 is the first one logic may read
  logic [1:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;  // Previous sampled levels
  logic [6:0] jmp1_q, jmp2_q;                // Jumper synchroniser stages
  // Bus target state
  recnt_pkg::recnt_bus_state_t st_q, st_d;
  logic [3:0] bits_q, bits_d;    // Bits moved in this byte
  logic [7:0] sh_q, sh_d;        // Shift register
  logic [4:0] idx_q, idx_d;      // Current register index
  logic addr_q, addr_d;          // Next byte is the address byte
  logic first_q, first_d;        // Next written byte is the index
  logic rw_q, rw_d;              // Transfer is a read
  logic sda_oe_q, sda_oe_d;      // Data pin pulled low
  logic [7:0] str_q, str_d;      // Stretch countdown
  // Register file
  logic [7:0] general_configuration_q, general_configuration_d, gconf2_q, gconf2_d, intcfg_q, intcfg_d, stat_q, stat_d;
  logic [31:0] wd_q [4];
  logic [31:0] wd_d [4];
  // Bus-to-register strobes from the bus machine
  logic wr_en, rd_en;
  logic [4:0] acc_idx;
  logic [7:0] rd_byte;
  recnt_pkg::recnt_step_t step;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Encoder front end on its own clock
  recnt_quad u_quad (
    .clk(clk),
    .rst_b(rst_b),
    .single_edge_counting(general_configuration_q[recnt_pkg::GC_SINGLE_BIT]),
    .step(step),
    .enc_clk(enc_clk),
    .enc_rst_b(enc_rst_b),
    .chan_a(chan_a),
    .chan_b(chan_b)
  );

  // Byte read decode; unmapped indexes read zero
  function automatic logic [7:0] rd_sel(input logic [4:0] i, input logic [7:0] g,
                                        input logic [7:0] g2, input logic [7:0] ic,
                                        input logic [7:0] s, input logic [31:0] w);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      recnt_pkg::IDX_GENERAL_CONFIGURATION: r = g;
      recnt_pkg::IDX_GCONF2: r = g2;
      recnt_pkg::IDX_INTCFG: r = ic;
      recnt_pkg::IDX_STATUS: r = s;
      default: if (i >= recnt_pkg::IDX_WORD0 && i <= recnt_pkg::IDX_LAST) r = w[i[1:0]*8 +: 8];
    endcase
    return r;
  endfunction : rd_sel

  // Word slot of an index in the word window
  function automatic logic [1:0] slot(input logic [4:0] i);
    logic [2:0] t;
    t = i[4:2] - 3'h2;
    return t[1:0];
  endfunction : slot

  assign acc_idx = idx_q;
  assign rd_byte = rd_sel(idx_q, general_configuration_q, gconf2_q, intcfg_q, stat_q, wd_q[slot(idx_q)]);

  // Edge and condition detection; 3 cycles of latency is far under 1.25 us half period
  assign scl_rise = scl_s_q[1] && !scl_p_q;
  assign scl_fall = !scl_s_q[1] && scl_p_q;
  assign start_c = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
  assign stop_c = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];

  // Bus target next state
  always_comb begin
    scl_s_d = {scl_s_q[0], scl_i};
    sda_s_d = {sda_s_q[0], sda_i};
    scl_p_d = scl_s_q[1];
    sda_p_d = sda_s_q[1];
    st_d = st_q;
    bits_d = bits_q;
    sh_d = sh_q;
    idx_d = idx_q;
    addr_d = addr_q;
    first_d = first_q;
    rw_d = rw_q;
    sda_oe_d = sda_oe_q;
    str_d = (str_q != 8'h00) ? str_q - 8'h01 : str_q;
    wr_en = 1'b0;
    rd_en = 1'b0;
    if (start_c) begin
      // Start or repeated start: expect address byte
      st_d = recnt_pkg::ST_RX;
      bits_d = 4'h0;
      addr_d = 1'b1;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = recnt_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        recnt_pkg::ST_RX: begin
          if (scl_rise && bits_q != 4'h8) begin
            sh_d = {sh_q[6:0], sda_s_q[1]};
            bits_d = bits_q + 4'h1;
          end else if (scl_fall && bits_q == 4'h8) begin
            if (addr_q) begin
              // Answer only our own jumper address
              if (sh_q[7:1] == jmp2_q) begin
                st_d = recnt_pkg::ST_ACK;
                sda_oe_d = 1'b1;
                rw_d = sh_q[0];
                first_d = !sh_q[0];
              end else begin
                st_d = recnt_pkg::ST_IDLE;
              end
              addr_d = 1'b0;
            end else begin
              st_d = recnt_pkg::ST_ACK;
              sda_oe_d = 1'b1;
              if (first_q) begin
                idx_d = sh_q[4:0];
                first_d = 1'b0;
              end else begin
                wr_en = 1'b1;
                idx_d = idx_q + 5'h01;
              end
            end
          end
        end
        recnt_pkg::ST_ACK: begin
          if (scl_fall) begin
            bits_d = 4'h0;
            if (rw_q) begin
              // Load the next read byte; stretch only if software allowed it
              st_d = recnt_pkg::ST_TX;
              sh_d = rd_byte;
              sda_oe_d = !rd_byte[7];
              rd_en = 1'b1;
              idx_d = idx_q + 5'h01;
              if (gconf2_q[recnt_pkg::GC2_STRETCH_BIT]) str_d = 8'(recnt_pkg::STRETCH_CYC);
            end else begin
              st_d = recnt_pkg::ST_RX;
              sda_oe_d = 1'b0;
            end
          end
        end
        recnt_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bits_q == 4'h7) begin
              st_d = recnt_pkg::ST_TXACK;
              sda_oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = !sh_q[6];
              bits_d = bits_q + 4'h1;
            end
          end
        end
        recnt_pkg::ST_TXACK: begin
          // Not-acknowledge ends the read; acknowledge sends another byte
          if (scl_rise && sda_s_q[1]) st_d = recnt_pkg::ST_IDLE;
          else if (scl_rise) st_d = recnt_pkg::ST_ACK;
        end
        default: st_d = recnt_pkg::ST_IDLE;
      endcase
    end
  end

  // Register file next state: encoder step, then bus write, status set wins clear
  always_comb begin
    logic [32:0] sum;
    logic [31:0] res;
    logic hit_max, hit_min;
    sum = 33'h0;
    res = wd_q[recnt_pkg::W_COUNT];
    hit_max = 1'b0;
    hit_min = 1'b0;
    general_configuration_d = general_configuration_q;
    gconf2_d = gconf2_q;
    intcfg_d = intcfg_q;
    stat_d = stat_q;
    wd_d = wd_q;
    if (rd_en && acc_idx == recnt_pkg::IDX_STATUS) stat_d = 8'h00;
    if (step.valid) begin
      // Signed arithmetic with one guard bit
      if (step.up) begin
        sum = {wd_q[0][31], wd_q[0]} + {wd_q[1][31], wd_q[1]};
        if ($signed(sum) > $signed({wd_q[2][31], wd_q[2]})) begin
          res = general_configuration_q[recnt_pkg::GC_WRAP_BIT] ? wd_q[3] : wd_q[2];
        end else begin
          res = sum[31:0];
        end
      end else begin
        sum = {wd_q[0][31], wd_q[0]} - {wd_q[1][31], wd_q[1]};
        if ($signed(sum) < $signed({wd_q[3][31], wd_q[3]})) begin
          res = general_configuration_q[recnt_pkg::GC_WRAP_BIT] ? wd_q[2] : wd_q[3];
        end else begin
          res = sum[31:0];
        end
      end
      hit_max = (res == wd_q[2]);
      hit_min = (res == wd_q[3]);
      wd_d[recnt_pkg::W_COUNT] = res;
      stat_d[recnt_pkg::ST_UP_BIT] = stat_d[recnt_pkg::ST_UP_BIT] | step.up;
      stat_d[recnt_pkg::ST_DOWN_BIT] = stat_d[recnt_pkg::ST_DOWN_BIT] | !step.up;
      stat_d[recnt_pkg::ST_MAX_BIT] = stat_d[recnt_pkg::ST_MAX_BIT] | hit_max;
      stat_d[recnt_pkg::ST_MIN_BIT] = stat_d[recnt_pkg::ST_MIN_BIT] | hit_min;
    end
    if (wr_en) begin
      // Bus write overrides a same-cycle counter update for that byte
      case (acc_idx)
        recnt_pkg::IDX_GENERAL_CONFIGURATION: general_configuration_d = sh_q;
        recnt_pkg::IDX_GCONF2: gconf2_d = sh_q;
        recnt_pkg::IDX_INTCFG: intcfg_d = sh_q;
        default: begin
          if (acc_idx >= recnt_pkg::IDX_WORD0 && acc_idx <= recnt_pkg::IDX_LAST) begin
            wd_d[slot(acc_idx)][acc_idx[1:0]*8 +: 8] = sh_q;
          end
        end
      endcase
    end
  end

  // All registers of the block
  always_ff @(posedge clk) begin
    jmp1_q <= address_jumper_inputs;
    jmp2_q <= jmp1_q;
    if (!rst_b) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= recnt_pkg::ST_IDLE;
      bits_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 5'h00;
      addr_q <= 1'b0;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      str_q <= 8'h00;
      general_configuration_q <= recnt_pkg::RST_CFG;
      gconf2_q <= recnt_pkg::RST_CFG;
      intcfg_q <= recnt_pkg::RST_CFG;
      stat_q <= recnt_pkg::RST_CFG;
      wd_q[0] <= recnt_pkg::RST_COUNT;
      wd_q[1] <= recnt_pkg::RST_INC;
      wd_q[2] <= recnt_pkg::RST_UPPER;
      wd_q[3] <= recnt_pkg::RST_LOWER;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      st_q <= st_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      addr_q <= addr_d;
      first_q <= first_d;
      rw_q <= rw_d;
      sda_oe_q <= sda_oe_d;
      str_q <= str_d;
      general_configuration_q <= general_configuration_d;
      gconf2_q <= gconf2_d;
      intcfg_q <= intcfg_d;
      stat_q <= stat_d;
      wd_q <= wd_d;
    end
  end

  // Pins: open drain, value always low, enables do the work
  assign scl_o = 1'b0;
  assign scl_oe = (str_q != 8'h00);
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign int_n_o = 1'b0;
  assign int_n_oe = |(stat_q & intcfg_q);

  // Checks
  sequence s_up_step;
    step.valid && step.up;
  endsequence
  AST_NO_STRETCH: assert property (@(posedge clk) disable iff (!rst_b)
    !gconf2_q[recnt_pkg::GC2_STRETCH_BIT] [*2] |-> !scl_oe)
    else $error("bus clock held while stretching disabled");
  AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == recnt_pkg::ST_RX && addr_q && scl_fall && bits_q == 4'h8 && sh_q[7:1] != jmp2_q)
    |=> !sda_oe && st_q == recnt_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  AST_STEP_ADD: assert property (@(posedge clk) disable iff (!rst_b)
    (s_up_step ##0 (!wr_en && $signed(wd_q[0]) < $signed(wd_q[2]) && $signed(wd_q[1]) == 1))
    |=> wd_q[0] == $past(wd_q[0]) + 32'h0000_0001)
    else $error("step did not add the increment");
  AST_SATURATE: assert property (@(posedge clk) disable iff (!rst_b)
    (s_up_step ##0 (!wr_en && !general_configuration_q[recnt_pkg::GC_WRAP_BIT] && wd_q[0] == wd_q[2]
     && $signed(wd_q[1]) > 0)) |=> wd_q[0] == $past(wd_q[2]))
    else $error("counter left the upper threshold without wrap");
  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    (step.valid && !step.up && !wr_en && general_configuration_q[recnt_pkg::GC_WRAP_BIT]
     && wd_q[0] == wd_q[3] && $signed(wd_q[1]) > 0) |=> wd_q[0] == $past(wd_q[2]))
    else $error("decrement past lower threshold did not wrap");
  AST_INT_PIN: assert property (@(posedge clk) disable iff (!rst_b)
    (s_up_step ##0 (!wr_en && intcfg_q[recnt_pkg::ST_MAX_BIT] && !general_configuration_q[recnt_pkg::GC_WRAP_BIT]
     && wd_q[0] == wd_q[2] && $signed(wd_q[1]) > 0) ##1 (!rd_en && !wr_en)) |-> int_n_oe [*2])
    else $error("enabled step event did not pull interrupt low");
  AST_STATUS_SET: assert property (@(posedge clk) disable iff (!rst_b)
    (step.valid && !step.up) |=> stat_q[recnt_pkg::ST_DOWN_BIT])
    else $error("down step not recorded in status");
  AST_INDEX_WR: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en |=> idx_q == $past(idx_q) + 5'h01 && st_q == recnt_pkg::ST_ACK)
    else $error("index did not advance after a register write");
endmodule : recnt_top
`default_nettype wire

/* recnt_host_model.sv */
// Behavioural two-wire bus controller that talks to the counter target.
// Assumes the bench resolves both open-drain lines with pull-ups.
`default_nettype none
module recnt_host_model #(
  parameter int HALF_CYC = 125,  // Half bus period in clk cycles, 400 kHz at most
  parameter int SETUP_CYC = 60   // Data set-up time ahead of the clock rise
) (
  // Clock
  input wire logic clk,
  // Resolved line levels
  input wire logic scl,
  input wire logic sda,
  // Pull-down requests, high pulls the line low
  output logic scl_pull,
  output logic sda_pull,
  // Raised if the target never lets the clock go high
  output logic clock_stuck
);
  // Both lines released at power-up
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    clock_stuck = 1'b0;
  end

  // One bit; a held-low clock delays the high phase, never shortens it
  task automatic xfer_bit(input logic v, output logic s);
    int n;
    sda_pull <= ~v;
    repeat (SETUP_CYC) @(posedge clk);
    scl_pull <= 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) clock_stuck <= 1'b1;
    repeat (HALF_CYC) @(posedge clk);
    s = sda;
    scl_pull <= 1'b1;
    repeat (HALF_CYC - SETUP_CYC) @(posedge clk);
  endtask : xfer_bit

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_pull <= 1'b0;
    repeat (SETUP_CYC) @(posedge clk);
    scl_pull <= 1'b0;
    repeat (HALF_CYC) @(posedge clk);
    sda_pull <= 1'b1;
    repeat (HALF_CYC) @(posedge clk);
    scl_pull <= 1'b1;
    repeat (HALF_CYC - SETUP_CYC) @(posedge clk);
  endtask : start

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_pull <= 1'b1;
    repeat (SETUP_CYC) @(posedge clk);
    scl_pull <= 1'b0;
    repeat (HALF_CYC) @(posedge clk);
    sda_pull <= 1'b0;
    repeat (HALF_CYC) @(posedge clk);
  endtask : stop

  // Eight bits out, most significant first, then the target's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], s);
    end
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Eight bits in; last byte gets a not-acknowledge to end the read
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      b[i] = s;
    end
    xfer_bit(last, s);
  endtask : recv_byte
endmodule : recnt_host_model
`default_nettype wire

/* tb_i2c_rotary_encoder_counter.sv */
// Self-checking bench for the rotary encoder counter target.
// Assumes recnt_pkg, recnt_top and recnt_host_model are compiled first.
`default_nettype none
module tb_i2c_rotary_encoder_counter;
  timeunit 1ns;
  timeprecision 1ps;
  // Clocks, resets, encoder and jumpers
  logic clk = 1'b0;
  logic enc_clk;
  logic rst_b, enc_rst_b, chan_a, chan_b;
  logic [6:0] jumpers;
  // Pin drives and resolved open-drain lines
  logic scl_oe, sda_oe, int_n_oe, host_scl, host_sda, scl_w, sda_w;
  logic scl_o, sda_o, int_n_o, int_w, clock_stuck;
  // Bookkeeping
  int err_count, tests_run, seed, k, lim;
  int stretch_cnt = 0;
  logic ack;
  logic [31:0] upper, lower, cnt;
  logic [7:0] wdat [0:7];
  logic [7:0] rdat [0:3];

  // Pull-ups win unless a driver is enabled; the target drives its output value
  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~host_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~host_sda;
  assign int_w = int_n_oe ? int_n_o : 1'b1;

  always #5 clk = ~clk;
  // Link clock offset so its edges never line up with clk
  initial begin
    enc_clk = 1'b0;
    #0.7;
    forever #3 enc_clk = ~enc_clk;
  end
  // Count cycles in which the target holds the bus clock low
  always @(posedge clk) begin
    if (scl_oe === 1'b1) stretch_cnt <= stretch_cnt + 1;
  end

  recnt_top dut_u (.clk(clk), .rst_b(rst_b), .enc_clk(enc_clk), .enc_rst_b(enc_rst_b),
    .chan_a(chan_a), .chan_b(chan_b), .address_jumper_inputs(jumpers), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe));
  recnt_host_model host_u (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_pull(host_scl),
    .sda_pull(host_sda), .clock_stuck(clock_stuck));

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Index byte then n data bytes to successive registers
  task automatic wr_regs(input logic [4:0] idx, input int n);
    host_u.start();
    host_u.send_byte({jumpers, 1'b0}, ack);
    check(ack, 1'b1);
    host_u.send_byte({3'h0, idx}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.send_byte(wdat[i], ack);
      check(ack, 1'b1);
    end
    host_u.stop();
  endtask : wr_regs

  // Set the index, repeated start, read n bytes onward
  task automatic rd_regs(input logic [4:0] idx, input int n);
    host_u.start();
    host_u.send_byte({jumpers, 1'b0}, ack);
    host_u.send_byte({3'h0, idx}, ack);
    host_u.start();
    host_u.send_byte({jumpers, 1'b1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.recv_byte(i == n - 1, rdat[i]);
    end
    host_u.stop();
  endtask : rd_regs

  // Direction channel settles well before the A edge
  task automatic enc(input logic a, input logic b);
    chan_b <= b;
    repeat (50) @(posedge clk);
    chan_a <= a;
    repeat (200) @(posedge clk);
  endtask : enc

  // Expected counter after one step, with reset increment
  function automatic logic [31:0] step_model(logic [31:0] c, logic up, logic wrap);
    logic signed [32:0] s;
    logic signed [32:0] inc;
    inc = $signed({1'b0, recnt_pkg::RST_INC});
    s = up ? $signed({c[31], c}) + inc : $signed({c[31], c}) - inc;
    if (s > $signed({upper[31], upper})) return wrap ? lower : upper;
    if (s < $signed({lower[31], lower})) return wrap ? upper : lower;
    return s[31:0];
  endfunction : step_model

  // Watchdog against a hung handshake; the full sequence takes just under 99k cycles
  initial begin
    repeat (101000) @(posedge clk);
    err_count++;
    summarize();
  end

  // Main sequence
  initial begin
    seed = 32'hE5AD;
    err_count = 0;
    tests_run = 0;
    rst_b = 1'b0;
    enc_rst_b = 1'b0;
    chan_a = 1'b1;
    chan_b = 1'b1;
    // At least two bits set, so a one-bit flip never forms address zero
    jumpers = 7'($random(seed)) | 7'h41;
    upper = 32'h2 + (32'($random(seed)) & 32'h3);
    lower = 32'h0 - 32'h1 - (32'($random(seed)) & 32'h3);
    cnt = recnt_pkg::RST_COUNT;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    enc_rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(sda_oe, 1'b0);
    check(int_n_oe, 1'b0);
    // Foreign address must be ignored
    host_u.start();
    host_u.send_byte({jumpers ^ (7'h01 << ({$random(seed)} % 7)), 1'b0}, ack);
    check(ack, 1'b0);
    host_u.stop();
    rd_regs(recnt_pkg::IDX_STATUS, 1);
    check(rdat[0], 8'h00);
    check(stretch_cnt, 0);
    // Stretch on, interrupt on upper threshold only
    wdat[0] = 8'h01;
    wdat[1] = 8'h04;
    wr_regs(recnt_pkg::IDX_GCONF2, 2);
    for (k = 0; k < 4; k++) begin
      wdat[k] = upper[8 * k +: 8];
      wdat[k + 4] = lower[8 * k +: 8];
    end
    wr_regs(recnt_pkg::IDX_WORD0 + 5'h08, 8);
    // Double-edge mode, saturate one step past the top
    lim = int'(upper) + 1;
    for (k = 0; k < lim; k++) begin
      if (chan_a) enc(1'b0, 1'b1);
      else enc(1'b1, 1'b0);
      cnt = step_model(cnt, 1'b1, 1'b0);
      check(int_w, cnt != upper);
    end
    rd_regs(recnt_pkg::IDX_WORD0, 1);
    check(rdat[0], cnt[7:0]);
    check(stretch_cnt, recnt_pkg::STRETCH_CYC);
    rd_regs(recnt_pkg::IDX_STATUS, 1);
    check(rdat[0], 8'h05);
    check(int_n_oe, 1'b0);
    // Single-edge mode with wrap; rising A edges must not count
    wdat[0] = 8'h03;
    wr_regs(recnt_pkg::IDX_GENERAL_CONFIGURATION, 1);
    enc(1'b1, 1'b0);
    enc(1'b0, 1'b1);
    cnt = step_model(cnt, 1'b1, 1'b1);
    rd_regs(recnt_pkg::IDX_WORD0, 2);
    check({rdat[1], rdat[0]}, cnt[15:0]);
    enc(1'b1, 1'b0);
    enc(1'b0, 1'b0);
    cnt = step_model(cnt, 1'b0, 1'b1);
    rd_regs(recnt_pkg::IDX_WORD0, 1);
    check(rdat[0], cnt[7:0]);
    check(clock_stuck, 1'b0);
    summarize();
  end
endmodule : tb_i2c_rotary_encoder_counter
`default_nettype wire
